// ==== hw/taec_pkg.sv ====
package taec_pkg;
	// bus geometry and answers
	localparam int ADDR_W = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// register byte offsets
	localparam logic [7:0] OFF_SCAN = 8'h00;
	localparam logic [7:0] OFF_ECTL = 8'h04;
	localparam logic [7:0] OFF_PEND = 8'h08;
	localparam logic [7:0] OFF_PDIR = 8'h0c;
	localparam logic [7:0] OFF_ACTEN = 8'h10;
	localparam logic [7:0] OFF_SWVEC = 8'h14;
	localparam logic [7:0] OFF_STAT = 8'h18;
	// field positions
	localparam int BIT_CNT_EN = 7;
	localparam int BIT_EDGE = 7;
	localparam int BIT_SWDTE = 7;
	localparam int SPAN_W = 4;
	localparam int VEC_W = 7;
	localparam int SCAN_RSV_W = 5;
	localparam int PDIR_W = 8;
	// reset values
	localparam logic [7:0] RST_SCAN = 8'h00;
	localparam logic [7:0] RST_ECTL = 8'h00;
	localparam logic [7:0] RST_PDIR = 8'h00;
	localparam logic [7:0] RST_SWVEC = 8'h00;
	// activation sources, software above all of them
	localparam int NSRC = 6;
	localparam int EVT_SRC = 5;
	localparam logic [6:0] SRC_VEC [NSRC] =
		'{7'h10, 7'h11, 7'h12, 7'h13, 7'h1c, 7'h1d};
	localparam logic [NSRC-1:0] RST_ACTEN = 6'h00;
	// vector table and descriptor layout
	localparam logic [23:0] VEC_BASE = 24'h000400;
	localparam logic [7:0] DESC_HI = 8'hff;
	localparam logic [2:0] DESC_LAST = 3'h5;
	localparam logic [23:0] DESC_STRIDE = 24'h00000c;
	localparam int CODE_W = 5;
	// descriptor mode fields
	localparam int SM_LSB = 6;
	localparam int DM_LSB = 4;
	localparam int MD_LSB = 2;
	localparam int BIT_SZ = 0;
	localparam int BIT_CHAIN_ENABLE = 7;
	localparam int BIT_PER_TRANSFER_IRQ_SELECT = 6;
	localparam logic [1:0] MD_REPEAT = 2'h1;
	localparam logic [1:0] AM_INC = 2'h2;
	localparam logic [1:0] AM_DEC = 2'h3;
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_VEC, ST_DRD, ST_XRD, ST_XWR, ST_DWR, ST_DONE
	} taec_state_t;
endpackage : taec_pkg

// ==== hw/taec_evt_chan.sv ====
`timescale 1ns/1ns
`default_nettype none
module taec_evt_chan (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic evtPin,
	input wire logic armed,
	input wire logic fallSel,
	input wire logic clrPulse,
	output logic pending
);
	logic prev_q;
	logic pend_q;
	logic edgeSeen;

	// previous pin level
	always_ff @(posedge clk) begin
		if (!rst_b) prev_q <= 1'b0;
		else prev_q <= evtPin;
	end

	assign edgeSeen = fallSel ? (prev_q & ~evtPin) : (~prev_q & evtPin);

	// set on edge, set beats clear
	always_ff @(posedge clk) begin
		if (!rst_b) pend_q <= 1'b0;
		else if (armed && edgeSeen) pend_q <= 1'b1;
		else if (clrPulse) pend_q <= 1'b0;
	end

	assign pending = pend_q;
endmodule : taec_evt_chan
`default_nettype wire

// ==== hw/taec_top.sv ====
// Summary of operation
// - count only while count enable set
// - edge select: 0 rising, 1 falling
// - span field enables inputs 0..span
// - port direction set ignores inputs 0-7
// - pending register 16 bits, read only
// - selected edge sets flag, yields code
// - any pending flag raises request
// - low five address bits = twice index
// - lowest pending input serviced first
// - read count word, write back plus one
// - clear serviced flag after transfer
// - count word at base plus twice index
// - count wraps to zero, no interrupt
// - events on pending input are dropped
// - start on enabled irq or sw write
// - end clears source flag or enable
// - fixed priority, software highest
// - descriptor fetched via vector entry
// - sw vector at base plus twice field
// - vector entry is low 16 address bits
// - event source uses vector twenty-nine
// - repeat low count reloads at zero
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module taec_top #(
	parameter int NEVT = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [taec_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [taec_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NEVT-1:0] eventPins,
	input wire logic [taec_pkg::NSRC-2:0] irqReq,
	output logic [taec_pkg::NSRC-2:0] irqClr,
	output logic eventPendingReq,
	output logic endIrq,
	output logic memReq,
	output logic memWe,
	output logic memByte,
	output logic [23:0] memAddr,
	output logic [15:0] memWdata,
	input wire logic memAck,
	input wire logic [15:0] memRdata
);
	import taec_pkg::*;

	// span field can reach sixteen inputs at most
	if (NEVT < 1 || NEVT > 16) begin : g_bad_nevt
		$error("NEVT must be 1 to 16");
	end

	taec_state_t state_q;
	logic [2:0] k_q;
	logic [23:0] base_q;
	logic [2:0] src_q;
	logic isSw_q;
	logic [6:0] vec_q;
	logic [3:0] evtIdx_q;
	logic [15:0] data_q;
	logic ended_q;
	logic [7:0] mra_q, mrb_q;
	logic [23:0] sar_q, dar_q;
	logic [15:0] cra_q, crb_q;
	logic cntEn_q, edge_q, swdte_q, swGo_q;
	logic [SCAN_RSV_W-1:0] scanRsv_q;
	logic [SPAN_W-1:0] span_q;
	logic [PDIR_W-1:0] pdir_q;
	logic [NSRC-1:0] actEn_q;
	logic [VEC_W-1:0] swVec_q;
	logic [ADDR_W-1:0] awAddr_q;
	logic awHeld_q, wHeld_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic [NEVT-1:0] pend, armed, evtClr;
	logic [15:0] pend16;
	logic [NSRC-1:0] hwReq;
	logic grantAny;
	logic [2:0] grantSrc;
	logic [3:0] evtFirst;
	logic evtXfer, finish, doWr, hit;
	logic [23:0] srcAddr, accAddr;
	logic [15:0] accWdata;
	logic accWe;
	logic [31:0] rdMux;

	// one edge catcher per event input
	for (genvar i = 0; i < NEVT; i++) begin : g_chan
		assign armed[i] = cntEn_q && (i <= int'(span_q)) &&
			!(i < PDIR_W && pdir_q[i % PDIR_W]);
		taec_evt_chan u_chan (
			.clk(clk),
			.rst_b(rst_b),
			.evtPin(eventPins[i]),
			.armed(armed[i]),
			.fallSel(edge_q),
			.clrPulse(evtClr[i]),
			.pending(pend[i])
		);
	end

	// flags widened to the 16-bit view
	assign pend16 = 16'(pend);
	assign eventPendingReq = |pend;

	always_comb begin
		evtFirst = 4'h0;
		for (int i = NEVT - 1; i >= 0; i--) begin
			if (pend[i]) evtFirst = 4'(i);
		end
	end

	always_comb begin
		for (int i = 0; i < NSRC; i++) begin
			if (i == EVT_SRC) hwReq[i] = actEn_q[i] && eventPendingReq;
			else hwReq[i] = actEn_q[i] && irqReq[i % (NSRC - 1)] &&
				!irqClr[i % (NSRC - 1)]; // stale while clear in flight
		end
	end

	// software first, then lowest source index
	always_comb begin
		grantAny = swGo_q;
		grantSrc = 3'h0;
		if (!swGo_q) begin
			for (int i = NSRC - 1; i >= 0; i--) begin
				if (hwReq[i]) begin
					grantAny = 1'b1;
					grantSrc = 3'(i);
				end
			end
		end
	end

	assign evtXfer = !isSw_q && (src_q == 3'(EVT_SRC));
	assign finish = mrb_q[BIT_PER_TRANSFER_IRQ_SELECT] || ended_q;
	assign srcAddr = evtXfer ? {sar_q[23:CODE_W], evtIdx_q, 1'b0} : sar_q;

	// access the current state asks for
	always_comb begin
		accAddr = base_q + {20'h00000, k_q, 1'b0};
		accWdata = 16'h0000;
		accWe = 1'b0;
		unique case (state_q)
			ST_VEC: accAddr = VEC_BASE + {16'h0000, vec_q, 1'b0};
			ST_XRD: accAddr = srcAddr;
			ST_XWR: begin
				accAddr = evtXfer ? {dar_q[23:CODE_W], evtIdx_q, 1'b0}
					: dar_q;
				accWe = 1'b1;
				accWdata = evtXfer ? data_q + 16'h0001 : data_q;
			end
			ST_DWR: begin
				accWe = 1'b1;
				unique case (k_q)
					3'h0: accWdata = {mra_q, sar_q[23:16]};
					3'h1: accWdata = sar_q[15:0];
					3'h2: accWdata = {mrb_q, dar_q[23:16]};
					3'h3: accWdata = dar_q[15:0];
					3'h4: accWdata = cra_q;
					default: accWdata = crb_q;
				endcase
			end
			default: ;
		endcase
	end

	// sequencer and memory port
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			memReq <= 1'b0;
			memWe <= 1'b0;
			memByte <= 1'b0;
			memAddr <= 24'h000000;
			memWdata <= 16'h0000;
			k_q <= 3'h0;
			base_q <= 24'h000000;
		end else if (state_q == ST_IDLE) begin
			if (grantAny) state_q <= ST_VEC;
		end else if (state_q == ST_DONE) begin
			state_q <= ST_IDLE;
		end else if (!memReq) begin
			memReq <= 1'b1;
			memAddr <= accAddr;
			memWdata <= accWdata;
			memWe <= accWe;
			memByte <= (state_q == ST_XRD || state_q == ST_XWR) &&
				!mra_q[BIT_SZ];
		end else if (memAck) begin
			memReq <= 1'b0;
			memWe <= 1'b0;
			unique case (state_q)
				ST_VEC: begin
					base_q <= {DESC_HI, memRdata};
					k_q <= 3'h0;
					state_q <= ST_DRD;
				end
				ST_DRD: begin
					k_q <= k_q + 3'h1;
					if (k_q == DESC_LAST) state_q <= ST_XRD;
				end
				ST_XRD: state_q <= ST_XWR;
				ST_XWR: begin
					k_q <= 3'h0;
					state_q <= ST_DWR;
				end
				ST_DWR: begin
					k_q <= k_q + 3'h1;
					if (k_q == DESC_LAST && mrb_q[BIT_CHAIN_ENABLE]) begin
						// chained descriptor follows directly
						base_q <= base_q + DESC_STRIDE;
						k_q <= 3'h0;
						state_q <= ST_DRD;
					end else if (k_q == DESC_LAST) begin
						state_q <= ST_DONE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// activation capture
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			isSw_q <= 1'b0;
			src_q <= 3'h0;
			vec_q <= 7'h00;
			evtIdx_q <= 4'h0;
		end else if (state_q == ST_IDLE && grantAny) begin
			isSw_q <= swGo_q;
			src_q <= grantSrc;
			vec_q <= swGo_q ? swVec_q : SRC_VEC[grantSrc];
			evtIdx_q <= evtFirst;
		end
	end

	// descriptor fields, data word and counts
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			{mra_q, mrb_q} <= 16'h0000;
			{sar_q, dar_q} <= 48'h000000000000;
			{cra_q, crb_q} <= 32'h00000000;
			data_q <= 16'h0000;
			ended_q <= 1'b0;
		end else if (memReq && memAck) begin
			if (state_q == ST_DRD) begin
				unique case (k_q)
					3'h0: {mra_q, sar_q[23:16]} <= memRdata;
					3'h1: sar_q[15:0] <= memRdata;
					3'h2: {mrb_q, dar_q[23:16]} <= memRdata;
					3'h3: dar_q[15:0] <= memRdata;
					3'h4: cra_q <= memRdata;
					default: crb_q <= memRdata;
				endcase
				ended_q <= 1'b0;
			end
			if (state_q == ST_XRD)
				data_q <= mra_q[BIT_SZ] ? memRdata
					: {8'h00, memRdata[7:0]};
			if (state_q == ST_XWR) begin
				sar_q <= stepAddr(sar_q, mra_q[SM_LSB+:2], mra_q[BIT_SZ]);
				dar_q <= stepAddr(dar_q, mra_q[DM_LSB+:2], mra_q[BIT_SZ]);
				if (mra_q[MD_LSB+:2] == MD_REPEAT) begin
					cra_q[7:0] <= (cra_q[7:0] == 8'h01) ? cra_q[15:8]
						: cra_q[7:0] - 8'h01;
				end else begin
					cra_q <= cra_q - 16'h0001;
					ended_q <= (cra_q == 16'h0001);
				end
			end
		end
	end

	// fixed, increment or decrement by size
	function automatic logic [23:0] stepAddr(
		input logic [23:0] a,
		input logic [1:0] m,
		input logic sz
	);
		logic [23:0] inc;
		inc = sz ? 24'h000002 : 24'h000001;
		if (m == AM_INC) return a + inc;
		if (m == AM_DEC) return a - inc;
		return a;
	endfunction : stepAddr

	always_comb begin
		evtClr = '0;
		if (state_q == ST_DONE && evtXfer && !finish)
			evtClr[evtIdx_q % NEVT] = 1'b1;
	end

	// source flag clear and end pulses
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			irqClr <= '0;
			endIrq <= 1'b0;
		end else begin
			irqClr <= '0;
			if (state_q == ST_DONE && !isSw_q && !evtXfer && !finish)
				irqClr[src_q % (NSRC - 1)] <= 1'b1;
			endIrq <= (state_q == ST_DONE) && finish;
		end
	end

	// axi write side
	assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
	assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
	assign doWr = awHeld_q && wHeld_q && !s_axi_bvalid;
	assign hit = awAddr_q inside {OFF_SCAN, OFF_ECTL, OFF_PEND,
		OFF_PDIR, OFF_ACTEN, OFF_SWVEC, OFF_STAT};

	// write address, data and response
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awAddr_q <= '0;
			wData_q <= 32'h00000000;
			wStrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWr) begin
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// control registers, low byte lane only
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			{cntEn_q, scanRsv_q} <= {RST_SCAN[7], RST_SCAN[4:0]};
			{edge_q, span_q} <= {RST_ECTL[7], RST_ECTL[3:0]};
			pdir_q <= RST_PDIR;
		end else if (doWr && wStrb_q[0]) begin
			if (awAddr_q == OFF_SCAN) begin
				cntEn_q <= wData_q[BIT_CNT_EN];
				scanRsv_q <= wData_q[SCAN_RSV_W-1:0];
			end
			if (awAddr_q == OFF_ECTL) begin
				edge_q <= wData_q[BIT_EDGE];
				span_q <= wData_q[SPAN_W-1:0];
			end
			if (awAddr_q == OFF_PDIR) pdir_q <= wData_q[PDIR_W-1:0];
		end
	end

	// activation enables, software write wins
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			actEn_q <= RST_ACTEN;
		end else begin
			if (state_q == ST_DONE && !isSw_q && finish)
				actEn_q[src_q] <= 1'b0;
			if (doWr && wStrb_q[0] && awAddr_q == OFF_ACTEN)
				actEn_q <= wData_q[NSRC-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			{swdte_q, swVec_q} <= RST_SWVEC;
			swGo_q <= 1'b0;
		end else begin
			if (state_q == ST_IDLE && swGo_q) swGo_q <= 1'b0;
			if (state_q == ST_DONE && isSw_q && !finish)
				swdte_q <= 1'b0;
			if (doWr && wStrb_q[0] && awAddr_q == OFF_SWVEC) begin
				if (wData_q[BIT_SWDTE] && !swdte_q) swGo_q <= 1'b1;
				swdte_q <= wData_q[BIT_SWDTE];
				if (!swdte_q) swVec_q <= wData_q[VEC_W-1:0];
			end
		end
	end

	// read value by address
	always_comb begin
		unique case (s_axi_araddr)
			OFF_SCAN: rdMux = {24'h000000, cntEn_q, 2'h0, scanRsv_q};
			OFF_ECTL: rdMux = {24'h000000, edge_q, 3'h0, span_q};
			OFF_PEND: rdMux = {16'h0000, pend16};
			OFF_PDIR: rdMux = {24'h000000, pdir_q};
			OFF_ACTEN: rdMux = {26'h0000000, actEn_q};
			OFF_SWVEC: rdMux = {24'h000000, swdte_q, swVec_q};
			OFF_STAT: rdMux = {31'h00000000, state_q != ST_IDLE};
			default: rdMux = 32'h00000000;
		endcase
	end

	// axi read side
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rdMux;
			s_axi_rresp <= (s_axi_araddr inside {OFF_SCAN, OFF_ECTL,
				OFF_PEND, OFF_PDIR, OFF_ACTEN, OFF_SWVEC, OFF_STAT})
				? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : taec_top
`default_nettype wire

// ==== test/taec_mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module taec_mem_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic memReq,
	input wire logic memWe,
	input wire logic [23:0] memAddr,
	input wire logic [15:0] memWdata,
	input wire logic [1:0] lat,
	output logic memAck,
	output logic [15:0] memRdata
);
	// word store: vector table, descriptors, counts
	logic [15:0] mem [logic [22:0]];
	logic [1:0] waitCnt_q;
	always @(posedge clk) begin
		memAck <= rst_b && memReq && !memAck && waitCnt_q == lat;
		if (!rst_b || !memReq || memAck) begin
			waitCnt_q <= 2'h0;
			memRdata <= rst_b ? ~memRdata : 16'h0000; // no stale data
		end else if (waitCnt_q != lat) begin
			waitCnt_q <= waitCnt_q + 2'h1;
			memRdata <= ~memRdata;
		end else begin
			waitCnt_q <= 2'h0;
			if (memWe) mem[memAddr[23:1]] = memWdata;
			memRdata <= (!memWe && mem.exists(memAddr[23:1]))
				? mem[memAddr[23:1]] : 16'h0000;
		end
	end
endmodule : taec_mem_model
`default_nettype wire

// ==== test/taec_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module taec_checker #(
	parameter int NEVT = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [taec_pkg::NSRC-2:0] irqClr,
	input wire logic endIrq,
	input wire logic memReq,
	input wire logic memWe,
	input wire logic [23:0] memAddr,
	input wire logic [15:0] memWdata,
	input wire logic memAck
);
	import taec_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// register bus answers
	a_bresp_held: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	a_read_held: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped early");
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 s_axi_bvalid) else $error("write answer late");
	a_read_refuse: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
	a_write_refuse: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	// memory side, output pulses and reset
	a_mem_hold: assert property (
		memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWe)
		&& $stable(memWdata)) else $error("memory request changed");
	a_mem_gap: assert property (
		memReq && memAck |=> !memReq) else $error("no idle after access");
	a_clr_pulse: assert property (
		|irqClr |=> irqClr == '0) else $error("source clear too long");
	a_end_pulse: assert property (
		endIrq |=> !endIrq) else $error("end pulse too long");
	a_reset_quiet: assert property (
		@(posedge clk) disable iff (1'b0)
		!rst_b |=> !memReq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("activity in reset");
	// main scenarios
	c_mem_write: cover property (memReq && memAck && memWe);
	c_end: cover property (endIrq);
	c_clr: cover property (|irqClr);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : taec_checker
bind taec_top taec_checker #(.NEVT(NEVT)) u_chk (.clk, .rst_b,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .irqClr, .endIrq,
	.memReq, .memWe, .memAddr, .memWdata, .memAck);
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import taec_pkg::*;
	localparam logic [23:0] CBASE = 24'hffe800;
	localparam logic [15:0] EVD [6] = '{16'h05ff, 16'he800, 16'h00ff,
		16'he800, 16'hffff, 16'hffff};
	localparam logic [15:0] SWD [6] = '{16'h01ff, 16'he900, 16'h00ff,
		16'he902, 16'h0001, 16'h0000};
	localparam logic [7:0] OFFS [7] = '{OFF_SCAN, OFF_ECTL, OFF_PEND,
		OFF_PDIR, OFF_ACTEN, OFF_SWVEC, OFF_STAT};
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] eventPins = 16'h0000;
	logic [NSRC-2:0] irqReq = '0, irqClr;
	logic eventPendingReq, endIrq, memReq, memWe, memByte, memAck;
	logic [23:0] memAddr;
	logic [15:0] memWdata, memRdata;
	logic [15:0] cntExp [16] = '{default: 16'h0000};
	logic [1:0] lat = 2'h0;
	logic [4:0] order [$];
	logic endSeen = 1'h0;
	logic byteSeen = 1'h0;
	int n_mismatch = 0, num_checks = 0, cyc = 0;

	always #2 clk = ~clk;
	taec_top #(.NEVT(16)) u_dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .eventPins, .irqReq,
		.irqClr, .eventPendingReq, .endIrq, .memReq, .memWe, .memByte,
		.memAddr, .memWdata, .memAck, .memRdata);
	taec_mem_model u_mem (.clk, .rst_b, .memReq, .memWe, .memAddr,
		.memWdata, .lat, .memAck, .memRdata);

	// watchdog, source drop on clear, count write log
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (endIrq) endSeen <= 1'h1;
		if (memReq && memByte) byteSeen <= 1'h1;
		if (irqClr[0]) irqReq[0] <= 1'h0;
		if (memAck && memWe && memAddr[23:5] == CBASE[23:5])
			order.push_back(memAddr[4:0]);
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results

	function automatic logic [15:0] mw(input logic [23:0] a);
		return u_mem.mem.exists(a[23:1]) ? u_mem.mem[a[23:1]] : 16'h0000;
	endfunction : mw

	function automatic void put(input logic [23:0] a, input logic [15:0] v);
		u_mem.mem[a[23:1]] = v;
	endfunction : put

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		logic aw;
		logic w;
		aw = 1'h1;
		w = 1'h1;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge clk);
			if (aw && s_axi_awready) begin
				aw = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (w && s_axi_wready) begin
				w = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'h0;
		chk("bresp", s_axi_bresp, er);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = RESP_OKAY);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		chk("rdata", s_axi_rdata, e);
		chk("rresp", s_axi_rresp, er);
	endtask : rd

	task automatic pulse(input logic [15:0] m);
		@(posedge clk);
		eventPins <= m;
		repeat (2) @(posedge clk);
		eventPins <= 16'h0000;
	endtask : pulse

	// wait until request and memory traffic stay quiet
	task automatic settle();
		int idle;
		idle = 0;
		while (idle < 8) begin
			@(posedge clk);
			idle = (eventPendingReq || memReq) ? 0 : idle + 1;
		end
	endtask : settle

	task automatic chkall();
		for (int i = 0; i < 16; i++)
			chk("count", mw(CBASE + 24'(2 * i)), cntExp[i]);
	endtask : chkall

	// main sequence
	initial begin
		for (int i = 0; i < 6; i++) begin
			put(24'hffec00 + 24'(2 * i), EVD[i]);
			put(24'hffec0c + 24'(2 * i), SWD[i]);
		end
		put(24'h00043a, 16'hec00);
		put(24'h000420, 16'hec0c);
		put(24'hffe900, 16'h5a3c);
		repeat (20) @(posedge clk);
		rst_b <= 1'h1;
		foreach (OFFS[i]) rd(OFFS[i], 32'h0);
		rd(8'h1c, 32'h0, RESP_SLVERR);
		wr(OFF_PEND, 32'hffff);
		rd(OFF_PEND, 32'h0);
		wr(8'h20, 32'h1, RESP_SLVERR);
		$display("test registers done");
		wr(OFF_ACTEN, 32'h20);
		wr(OFF_ECTL, 32'h0f);
		pulse(16'h0008);
		settle();
		rd(OFF_PEND, 32'h0);
		chkall();
		$display("test count disable done");
		wr(OFF_SCAN, 32'h80);
		order.delete();
		pulse(16'h8005);
		settle();
		chk("writes", order.size(), 3);
		chk("code", order[0], 5'h00);
		chk("code", order[1], 5'h04);
		chk("code", order[2], 5'h1e);
		cntExp[0] = 16'h1;
		cntExp[2] = 16'h1;
		cntExp[15] = 16'h1;
		chkall();
		chk("repeat", mw(24'hffec08), 16'hfffc);
		$display("test priority done");
		put(CBASE + 24'h2, 16'hffff);
		put(24'hffec08, 16'hff01);
		pulse(16'h0002);
		settle();
		chkall();
		chk("reload", mw(24'hffec08), 16'hffff);
		$display("test wrap done");
		lat <= 2'h3;
		pulse(16'h0010);
		pulse(16'h0010);
		rd(OFF_PEND, 32'h10);
		chk("request", eventPendingReq, 1'h1);
		settle();
		lat <= 2'h0;
		cntExp[4] = 16'h1;
		chkall();
		rd(OFF_PEND, 32'h0);
		$display("test pending done");
		wr(OFF_ECTL, 32'h02);
		pulse(16'h000c);
		settle();
		cntExp[2] = 16'h2;
		chkall();
		wr(OFF_ECTL, 32'h0f);
		wr(OFF_PDIR, 32'h01);
		pulse(16'h0101);
		settle();
		cntExp[8] = 16'h1;
		chkall();
		wr(OFF_PDIR, 32'h00);
		wr(OFF_ECTL, 32'h8f);
		eventPins <= 16'h0020;
		repeat (4) @(posedge clk);
		rd(OFF_PEND, 32'h0);
		eventPins <= 16'h0000;
		settle();
		cntExp[5] = 16'h1;
		chkall();
		wr(OFF_ECTL, 32'h0f);
		$display("test input select done");
		wr(OFF_SWVEC, 32'h90);
		settle();
		chk("copy", mw(24'hffe902), 16'h5a3c);
		chk("end", endSeen, 1'h1);
		rd(OFF_SWVEC, 32'h90);
		wr(OFF_SWVEC, 32'h00);
		put(24'hffe900, 16'h1111);
		wr(OFF_ACTEN, 32'h21);
		irqReq[0] <= 1'h1;
		settle();
		chk("copy", mw(24'hffe902), 16'h1111);
		chk("cleared", irqReq[0], 1'h0);
		chk("once", mw(24'hffec14), 16'hffff);
		rd(OFF_ACTEN, 32'h21);
		chk("byte", byteSeen, 1'h0);
		$display("test activation done");
		results();
	end
endmodule : testbench
`default_nettype wire
